// *** rtl/bus_sizing_pkg.sv ***
// Constants shared by the dynamic bus sizing sequencer and its lane mux
package bus_sizing_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   // Acknowledge pair encodings {hi, lo}
   localparam logic [1:0] ACK_WAIT = 2'h3;
   localparam logic [1:0] ACK_PORT8 = 2'h2;
   localparam logic [1:0] ACK_PORT16 = 2'h1;
   localparam logic [1:0] ACK_PORT32 = 2'h0;
   // Remaining size codes {hi, lo}
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   // Operand byte counts
   localparam logic [2:0] BYTES_ONE = 3'h1;
   localparam logic [2:0] BYTES_TWO = 3'h2;
   localparam logic [2:0] BYTES_FOUR = 3'h4;
   // Port widths in bytes
   localparam logic [2:0] PORT8_BYTES = 3'h1;
   localparam logic [2:0] PORT16_BYTES = 3'h2;
   localparam logic [2:0] PORT32_BYTES = 3'h4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CYCLE = 2'b01,
      ST_DONE = 2'b10
   } seq_state_e;
endpackage : bus_sizing_pkg

// *** rtl/lane_mux.sv ***
// Write lane replication for the external data bus
`timescale 1ns/1ps
`default_nettype none
module lane_mux
   import bus_sizing_pkg::*;
(
   input wire logic [1:0] size_code_i,
   input wire logic [1:0] offset_i,
   input wire logic [31:0] operand_i,
   output logic [31:0] lanes_o
);
   logic [7:0] op0, op1, op2, op3;
   logic [7:0] first, second, third, fourth;
   assign op0 = operand_i[31:24];
   assign op1 = operand_i[23:16];
   assign op2 = operand_i[15:8];
   assign op3 = operand_i[7:0];

   // Bytes in the order they go out, by remaining size
   always_comb begin
      case (size_code_i)
         SIZE_BYTE: begin
            first = op3; second = op3; third = op3; fourth = op3;
         end
         SIZE_WORD: begin
            first = op2; second = op3; third = op3; fourth = op3;
         end
         SIZE_THREE: begin
            first = op1; second = op2; third = op3; fourth = op3;
         end
         default: begin
            first = op0; second = op1; third = op2; fourth = op3;
         end
      endcase
   end

   // Each offset aligns first byte to its lane and mirrors it upward
   always_comb begin
      case (offset_i)
         2'h0: lanes_o = {first, second, third, fourth};
         2'h1: lanes_o = {first, first, second, third};
         2'h2: lanes_o = {first, second, first, second};
         default: lanes_o = {first, first, second, first};
      endcase
   end
endmodule : lane_mux
`default_nettype wire

// *** rtl/dynamic_bus_sizing_mux.sv ***
// Dynamic bus sizing sequencer with read assembly and write lane mux
// Notes on behaviour
// - Ack pair: 11 wait, 10 byte port, 01 word port, 00 long port.
// - Port width is learned from the acknowledge ending every cycle.
// - Aligned long read takes one, two or four cycles by port width.
// - Each cycle tries to move all remaining bytes; long starts as 32-bit.
// - Operand byte 0 is most significant; byte 3 least.
// - Write lane routing depends only on size code and two low address bits.
// - Size code: 01 one, 10 two, 11 three, 00 four bytes remaining.
// - Bytes moved may be fewer than the size code shows.
// - Upper address is long-word base; two low bits give byte offset.
// - Read bytes come from lanes set by offset and port width.
// - Code fetch passes requested word, caches both bus words from a 32-bit port only.
// - Aligned long write to word port continues with word size, offset two.
// - Wait while ack pair negated; latch read data only on width ack.
// - Writes drive all 32 data lanes every cycle.
// - Write bytes are mirrored onto lanes by size code and offset.
// - Cycle count follows operand size, alignment and port width.
`timescale 1ns/1ps
`default_nettype none
module dynamic_bus_sizing_mux
   import bus_sizing_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic req_code_i,
   input wire logic [2:0] req_bytes_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic [DATA_W-1:0] cache_line_o,
   output logic cache_fill_o,
   output logic cycle_active_o,
   output logic write_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic remaining_size_hi_o,
   output logic remaining_size_lo_o,
   output logic [DATA_W-1:0] data_out_o,
   output logic data_oe_n_o,
   input wire logic [DATA_W-1:0] data_in_i,
   input wire logic port_ack_hi_i,
   input wire logic port_ack_lo_i
);
   seq_state_e state;
   logic [2:0] remaining;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] operand;
   logic write, code;
   logic [1:0] ack_s1, ack_s2, ack_s3;
   logic [1:0] port_ack_pair;
   logic ack_seen, ack_armed;
   logic [1:0] remaining_size_code;
   logic [1:0] offset;
   logic [2:0] port_bytes, room, moved;
   logic [DATA_W-1:0] lanes, next_operand;
   logic [31:0] din_s;

   assign offset = addr[1:0];
   assign remaining_size_code = remaining[1:0];
   assign remaining_size_hi_o = remaining_size_code[1];
   assign remaining_size_lo_o = remaining_size_code[0];

   // Acknowledge pins pass three flops; change taken when last two agree
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ack_s1 <= ACK_WAIT;
         ack_s2 <= ACK_WAIT;
         ack_s3 <= ACK_WAIT;
         port_ack_pair <= ACK_WAIT;
      end else begin
         ack_s1 <= {port_ack_hi_i, port_ack_lo_i};
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         if (ack_s2 == ack_s3)
            port_ack_pair <= ack_s3;
      end
   end

   // Width from each ending acknowledge; no stored configuration
   always_comb begin
      case (port_ack_pair)
         ACK_PORT8: port_bytes = PORT8_BYTES;
         ACK_PORT16: port_bytes = PORT16_BYTES;
         default: port_bytes = PORT32_BYTES;
      endcase
   end
   assign ack_seen = (state == ST_CYCLE) && (port_ack_pair != ACK_WAIT)
      && (ack_s2 == ack_s3) && (ack_s3 == port_ack_pair)
      && ack_armed;

   // One acceptance per width level; rearmed once the pair reads wait
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i)
         ack_armed <= 1'b1;
      else if (ack_seen)
         ack_armed <= 1'b0;
      else if (port_ack_pair == ACK_WAIT)
         ack_armed <= 1'b1;
   end

   // Bytes reachable before the next port boundary
   always_comb begin
      case (port_bytes)
         PORT8_BYTES: room = 3'h1;
         PORT16_BYTES: room = offset[0] ? 3'h1 : 3'h2;
         default: room = 3'h4 - {1'b0, offset};
      endcase
      moved = (room < remaining) ? room : remaining;
   end

   // Read bytes: port lane for offset, into high end of remaining field
   always_comb begin
      din_s = data_in_i;
      next_operand = operand;
      for (int i = 0; i < 4; i++) begin
         if (i < moved) begin
            logic [1:0] lane;
            lane = 2'h0;
            case (port_bytes)
               PORT8_BYTES: lane = 2'h0;
               PORT16_BYTES: lane = 2'(offset[0] + i);
               default: lane = 2'(offset + i);
            endcase
            next_operand[8*(remaining-1-i) +: 8] =
               din_s[8*(3-lane) +: 8];
         end
      end
   end

   lane_mux u_lane_mux (
      .size_code_i(remaining_size_code),
      .offset_i(offset),
      .operand_i(operand),
      .lanes_o(lanes)
   );

   // Sequencer
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         remaining <= 3'h0;
         addr <= '0;
         operand <= '0;
         write <= 1'b0;
         code <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req_valid_i) begin
                  state <= ST_CYCLE;
                  remaining <= req_bytes_i;
                  addr <= req_addr_i;
                  operand <= req_wdata_i;
                  write <= req_write_i;
                  code <= req_code_i;
               end
            end
            ST_CYCLE: begin
               if (ack_seen) begin
                  if (!write)
                     operand <= next_operand;
                  addr <= addr + ADDR_W'(moved);
                  remaining <= remaining - moved;
                  if (remaining == moved)
                     state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Results and cache fill for code fetches
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         done_o <= 1'b0;
         rdata_o <= '0;
         cache_line_o <= '0;
         cache_fill_o <= 1'b0;
      end else begin
         done_o <= ack_seen && (remaining == moved);
         cache_fill_o <= 1'b0;
         if (ack_seen && !write && remaining == moved)
            rdata_o <= next_operand;
         if (ack_seen && !write && code && port_bytes == PORT32_BYTES) begin
            cache_line_o <= data_in_i;
            cache_fill_o <= 1'b1;
         end
      end
   end

   // Bus outputs from flops
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         data_out_o <= '0;
         data_oe_n_o <= 1'b1;
         addr_o <= '0;
         write_o <= 1'b0;
      end else begin
         data_out_o <= lanes;
         data_oe_n_o <= !(state == ST_CYCLE && write && !ack_seen);
         addr_o <= ack_seen ? addr + ADDR_W'(moved) : addr;
         write_o <= write;
      end
   end
   assign cycle_active_o = (state == ST_CYCLE);
   assign req_ready_o = (state == ST_IDLE);

   a_wait_holds: assert property (@(posedge clock_i) disable iff (rst_i)
      state == ST_CYCLE && port_ack_pair == ACK_WAIT |=>
      $stable(remaining) && $stable(addr))
      else $error("cycle moved during wait");
   a_count_drops: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen |=> remaining == $past(remaining) - $past(moved))
      else $error("remaining count wrong");
   a_long_start: assert property (@(posedge clock_i) disable iff (rst_i)
      state == ST_IDLE && req_valid_i && req_bytes_i == BYTES_FOUR |=>
      remaining_size_code == SIZE_LONG)
      else $error("long not started as four bytes");
   a_port8_one: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && port_ack_pair == ACK_PORT8 |-> moved == 3'h1)
      else $error("byte port moved more than one");
   a_done_end: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && remaining == moved |=> done_o && state == ST_DONE)
      else $error("done not raised");
   a_write_lanes: assert property (@(posedge clock_i) disable iff (rst_i)
      state == ST_CYCLE && write && remaining == BYTES_FOUR
      && offset == 2'h0 |-> lanes == operand)
      else $error("aligned long lanes wrong");
   a_word_half: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && port_ack_pair == ACK_PORT16 && remaining == BYTES_FOUR
      && offset == 2'h0 |=> remaining == BYTES_TWO && offset == 2'h2)
      else $error("word port continuation wrong");
   a_addr_step: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen |=> addr == $past(addr) + ADDR_W'($past(moved)))
      else $error("address not advanced");
   a_one_accept: assert property (@(posedge clock_i) disable iff (rst_i)
      ack_seen |=> !ack_seen)
      else $error("held acknowledge taken twice");
   c_long_32: cover property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && port_ack_pair == ACK_PORT32 && remaining == BYTES_FOUR);
   c_long_16: cover property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && port_ack_pair == ACK_PORT16 && remaining == BYTES_TWO);
   c_byte_port: cover property (@(posedge clock_i) disable iff (rst_i)
      ack_seen && port_ack_pair == ACK_PORT8 && remaining == BYTES_ONE);
endmodule : dynamic_bus_sizing_mux
`default_nettype wire

// *** tb/port_slave.sv ***
// Behavioural 8/16/32-bit slave port on fixed lanes
`timescale 1ns/1ps
`default_nettype none
module port_slave
   import bus_sizing_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic act_i,
   input wire logic wr_i,
   input wire logic [31:0] addr_i,
   input wire logic [1:0] size_i,
   input wire logic [31:0] dout_i,
   input wire logic [1:0] width_i,
   input wire logic [3:0] wait_i,
   output logic [31:0] din_o,
   output logic [1:0] ack_o,
   output logic [7:0] acks_o
);
   logic [7:0] m [8];
   logic [7:0] pat;
   logic [3:0] w;
   logic srv;
   logic [33:0] key;
   int wb, mv, of;
   always_comb begin
      wb = (width_i == ACK_PORT32) ? 4 : (width_i == ACK_PORT16) ? 2 : 1;
      of = int'(addr_i[1:0]) % wb;
      mv = (size_i == 2'h0) ? 4 : int'(size_i);
      if (mv > wb - of)
         mv = wb - of;
      // Released lanes toggle every cycle
      din_o = {4{pat}};
      if (srv && !wr_i)
         for (int k = 0; k < wb; k++)
            din_o[31-8*k -: 8] = m[3'((int'(addr_i[2:0]) & ~(wb-1)) + k)];
   end
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         srv <= 1'b0;
         w <= 4'h0;
         ack_o <= ACK_WAIT;
         acks_o <= 8'h0;
         pat <= 8'h0;
         key <= '0;
         for (int i = 0; i < 8; i++)
            m[i] <= 8'ha0 + 8'(i);
      end else begin
         pat <= pat + 8'h5b;
         if (srv) begin
            if (!act_i || {addr_i, size_i} != key) begin
               srv <= 1'b0;
               w <= 4'h0;
               ack_o <= ACK_WAIT;
            end
         end else if (act_i) begin
            if (w < wait_i) begin
               w <= w + 4'h1;
            end else begin
               srv <= 1'b1;
               key <= {addr_i, size_i};
               ack_o <= width_i;
               acks_o <= acks_o + 8'h1;
               if (wr_i)
                  for (int i = 0; i < mv; i++)
                     m[3'(int'(addr_i[2:0]) + i)] <= dout_i[31-8*(of+i) -: 8];
            end
         end
      end
   end
endmodule : port_slave
`default_nettype wire

// *** tb/dynamic_bus_sizing_mux_tb.sv ***
// Self-checking bench for the dynamic bus sizing sequencer
`timescale 1ns/1ps
`default_nettype none
module dynamic_bus_sizing_mux_tb;
   import bus_sizing_pkg::*;
   logic clock_i = 0, rst_i = 1, rv = 0, rw = 0, rc = 0;
   logic [2:0] rb = 3'h0;
   logic [31:0] ra = '0, rd = '0, din, dout, rdata, cline, addr, line;
   logic [1:0] ack, width = ACK_PORT32, sz;
   logic [3:0] wt = 4'h2;
   logic [7:0] acks;
   logic ready, done, fill, act, wr, shi, slo, oe_n, oe_seen;
   int errors = 0, cmp_count = 0, cyc = 0, lat, n_ack, n_fill;
   logic [1:0] wc [3] = '{ACK_PORT32, ACK_PORT16, ACK_PORT8};
   int wbs [3] = '{4, 2, 1};
   dynamic_bus_sizing_mux i_dut (.clock_i(clock_i), .rst_i(rst_i),
      .req_valid_i(rv), .req_ready_o(ready), .req_write_i(rw),
      .req_code_i(rc), .req_bytes_i(rb), .req_addr_i(ra), .req_wdata_i(rd),
      .done_o(done), .rdata_o(rdata), .cache_line_o(cline),
      .cache_fill_o(fill), .cycle_active_o(act), .write_o(wr), .addr_o(addr),
      .remaining_size_hi_o(shi), .remaining_size_lo_o(slo),
      .data_out_o(dout), .data_oe_n_o(oe_n), .data_in_i(din),
      .port_ack_hi_i(ack[1]), .port_ack_lo_i(ack[0]));
   port_slave i_slv (.clock_i(clock_i), .rst_i(rst_i), .act_i(act),
      .wr_i(wr), .addr_i(addr), .size_i({shi, slo}), .dout_i(dout),
      .width_i(width), .wait_i(wt), .din_o(din), .ack_o(ack), .acks_o(acks));
   always #10 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   function automatic int ncyc(int wb, int nb, int off);
      int c, mv;
      c = 0;
      while (nb > 0) begin
         mv = wb - off % wb;
         if (mv > nb)
            mv = nb;
         nb -= mv;
         off += mv;
         c++;
      end
      return c;
   endfunction : ncyc
   function automatic logic [31:0] ev(int nb, int off);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < nb; i++)
         v = {v[23:0], 8'ha0 + 8'(off + i)};
      return v;
   endfunction : ev
   task automatic op(input logic w, c, input int nb, input logic [31:0] a, d);
      logic [7:0] a0;
      logic got;
      a0 = acks;
      got = 0;
      lat = 0;
      n_fill = 0;
      oe_seen = 0;
      @(posedge clock_i);
      rv <= 1'b1;
      rw <= w;
      rc <= c;
      rb <= 3'(nb);
      ra <= a;
      rd <= d;
      @(posedge clock_i);
      rv <= 1'b0;
      do begin
         @(negedge clock_i);
         lat++;
         if (act === 1'b1 && !got) begin
            sz = {shi, slo};
            got = 1;
         end
         if (oe_n === 1'b0)
            oe_seen = 1;
         if (fill === 1'b1) begin
            n_fill++;
            line = cline;
         end
      end while (done !== 1'b1 && lat < 400);
      n_ack = int'(acks - a0);
      if (lat >= 400) begin
         errors++;
         $display("[FAIL] %0t no completion", $time);
      end
   endtask : op
   task automatic t_reads();
      for (int p = 0; p < 3; p++)
         for (int o = 0; o < 4; o++) begin
            width <= wc[p];
            op(0, 0, 4, 32'h100 + o, 0);
            chk(rdata, ev(4, o));
            chk(n_ack, ncyc(wbs[p], 4, o));
            chk(sz, SIZE_LONG);
         end
      $display("read test done");
   endtask : t_reads
   task automatic t_code();
      width <= ACK_PORT32;
      op(0, 1, 2, 32'h2, 0);
      chk(rdata[15:0], ev(2, 2));
      chk(n_fill, 1);
      chk(line, ev(4, 0));
      width <= ACK_PORT16;
      op(0, 1, 2, 32'h2, 0);
      chk(n_fill, 0);
      $display("code fetch test done");
   endtask : t_code
   task automatic t_wait();
      int l2;
      width <= ACK_PORT8;
      op(0, 0, 4, 32'h0, 0);
      l2 = lat;
      wt <= 4'h9;
      op(0, 0, 4, 32'h0, 0);
      chk(lat - l2, 28);
      chk(rdata, ev(4, 0));
      wt <= 4'h2;
      $display("wait state test done");
   endtask : t_wait
   task automatic t_writes();
      logic [31:0] d, mk;
      int nb;
      for (int p = 0; p < 3; p++)
         for (int s = 0; s < 3; s++)
            for (int o = 0; o < 4; o++) begin
               nb = 1 << s;
               mk = (nb == 4) ? '1 : (32'h1 << (8 * nb)) - 32'h1;
               d = 32'h5a3c9617 + 32'(p * 16 + s * 4 + o) * 32'h01010101;
               width <= wc[p];
               op(1, 0, nb, 32'h200 + o, d);
               chk(n_ack, ncyc(wbs[p], nb, o));
               chk(sz, nb[1:0]);
               chk(oe_seen, 1);
               op(0, 0, nb, 32'h200 + o, 0);
               chk(rdata & mk, d & mk);
            end
      $display("write test done");
   endtask : t_writes
   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      t_reads();
      t_code();
      t_wait();
      t_writes();
      report_and_stop();
   end
endmodule : dynamic_bus_sizing_mux_tb
`default_nettype wire
